// ==== sxe_params.svh ====
`ifndef SXE_PARAMS_SVH
`define SXE_PARAMS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SXE_ADDR_W 24
`define SXE_LONG_W 32
`define SXE_WORD_W 16
`define SXE_BYTE_W 8
`define SXE_REMAIN_W 19
`define SXE_ILEN_W 4

// ----------------------------------------
// reset values
// ----------------------------------------
// interrupt mask bit set, all other flags clear
`define SXE_FLAGS_RST 8'h80

// ----------------------------------------
// field positions in a memory word
// ----------------------------------------
// flag register sits in the upper byte of a word operand
`define SXE_FLAG_HI 15
`define SXE_FLAG_LO 8
`define SXE_LOW_HI 7
`define SXE_LOW_LO 0
`define SXE_PC_TOP_HI 23
`define SXE_PC_TOP_LO 16
`define SXE_PC_BOT_HI 15
`define SXE_PC_BOT_LO 0
`define SXE_PAD_BYTE 8'h00
`define SXE_ZERO_BYTE 8'h00
`define SXE_ZERO_WORD 16'h0000

// ----------------------------------------
// steps
// ----------------------------------------
`define SXE_PTR_STEP 32'h00000002
`define SXE_SP_STEP 32'h00000002
`define SXE_ADDR_STEP 24'h000002
`define SXE_CNT_STEP 16'h0001
`define SXE_CNT_BYTE_STEP 8'h01

// ----------------------------------------
// timing, in core clock cycles (one state each)
// ----------------------------------------
`define SXE_COPY_OVH 19'h00008
`define SXE_COPY_PER_SH 2
// start cycle plus done cycle plus one register stage
`define SXE_COPY_LEAD 19'h00003
`define SXE_COPY_LAST 19'h00001
`define SXE_REMAIN_STEP 19'h00001
`define SXE_POP_FLAGS 2'h0
`define SXE_POP_PC_TOP 2'h1
`define SXE_POP_PC_BOT 2'h2
`define SXE_PH_READ 2'h0
`define SXE_PH_WAIT 2'h1
`define SXE_PH_WRITE 2'h2
`define SXE_PH_STEP 2'h3
`define SXE_PH_INC 2'h1

`endif

// ==== sxe_pkg.sv ====
`default_nettype none
`include "sxe_params.svh"

package sxe_pkg;

	typedef enum logic [3:0] {
		SXE_OP_NOP,
		SXE_OP_SLEEP,
		SXE_OP_RETURN_FROM_EXCEPTION,
		SXE_OP_FLAG_LOAD,
		SXE_OP_FLAG_STORE,
		SXE_OP_FLAG_AND_IMMEDIATE,
		SXE_OP_FLAG_OR_IMMEDIATE,
		SXE_OP_FLAG_XOR_IMMEDIATE,
		SXE_OP_BLOCK_COPY_BYTE,
		SXE_OP_BLOCK_COPY_WORD
	} sxe_op_t;

	typedef enum logic [3:0] {
		SXE_AM_IMM,
		SXE_AM_REG,
		SXE_AM_IND,
		SXE_AM_D16,
		SXE_AM_D24,
		SXE_AM_INC,
		SXE_AM_DEC,
		SXE_AM_ABS16,
		SXE_AM_ABS24
	} sxe_mode_t;

	typedef enum logic [2:0] {
		SXE_S_IDLE,
		SXE_S_RD,
		SXE_S_DATA,
		SXE_S_WR,
		SXE_S_COPY,
		SXE_S_PAD
	} sxe_fsm_t;

	typedef struct packed {
		sxe_op_t op;
		sxe_mode_t mode;
		logic [`SXE_BYTE_W-1:0] imm;
		logic [`SXE_BYTE_W-1:0] byte_reg;
		logic [`SXE_LONG_W-1:0] ptr;
		logic [`SXE_ADDR_W-1:0] disp;
		logic [`SXE_ADDR_W-1:0] abs_addr;
		logic [`SXE_LONG_W-1:0] sp;
		logic [`SXE_ADDR_W-1:0] pc;
		logic [`SXE_ILEN_W-1:0] ilen;
		logic [`SXE_WORD_W-1:0] word_count_reg;
		logic [`SXE_WORD_W-1:0] source_pointer;
		logic [`SXE_WORD_W-1:0] destination_pointer;
	} sxe_cmd_t;

	typedef struct packed {
		logic [`SXE_ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic byte_en;
		logic [`SXE_WORD_W-1:0] wdata;
	} sxe_mem_t;

	typedef struct packed {
		logic [`SXE_LONG_W-1:0] sp;
		logic sp_we;
		logic [`SXE_ADDR_W-1:0] pc;
		logic pc_we;
		logic [`SXE_LONG_W-1:0] ptr;
		logic ptr_we;
		logic [`SXE_BYTE_W-1:0] byte_out;
		logic byte_we;
		logic [`SXE_WORD_W-1:0] source_pointer;
		logic [`SXE_WORD_W-1:0] destination_pointer;
		logic [`SXE_WORD_W-1:0] word_count_reg;
		logic copy_we;
	} sxe_wb_t;

	typedef struct packed {
		sxe_fsm_t fsm;
		sxe_cmd_t cmd;
		logic [`SXE_REMAIN_W-1:0] remain;
		logic [1:0] phase;
		logic [1:0] pop;
		logic [`SXE_BYTE_W-1:0] flags;
		sxe_mem_t mem;
		sxe_wb_t wb;
		logic sleep_req;
		logic busy;
		logic done;
	} sxe_state_t;

endpackage
`default_nettype wire

// ==== sxe_flag_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxe_params.svh"

module sxe_flag_alu (
	// operation
	input wire sxe_pkg::sxe_op_t op,
	input wire sxe_pkg::sxe_mode_t mode,
	// operands
	input wire logic [`SXE_BYTE_W-1:0] flag_register,
	input wire logic [`SXE_BYTE_W-1:0] imm,
	input wire logic [`SXE_BYTE_W-1:0] byte_reg,
	input wire logic [`SXE_WORD_W-1:0] mem_word,
	// result
	output logic [`SXE_BYTE_W-1:0] result
);
	import sxe_pkg::*;

	always_comb begin
		result = flag_register;
		unique case (op)
			SXE_OP_FLAG_AND_IMMEDIATE: result = flag_register & imm;
			SXE_OP_FLAG_OR_IMMEDIATE: result = flag_register | imm;
			SXE_OP_FLAG_XOR_IMMEDIATE: result = flag_register ^ imm;
			SXE_OP_FLAG_LOAD: begin
				if (mode == SXE_AM_IMM) begin
					result = imm;
				end else if (mode == SXE_AM_REG) begin
					result = byte_reg;
				end else begin
					result = mem_word[`SXE_FLAG_HI:`SXE_FLAG_LO];
				end
			end
			default: result = flag_register;
		endcase
	end

endmodule
`default_nettype wire

// ==== sxe_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxe_params.svh"

// Behaviour
// - return pops the flag word first, then the program counter, adding two to the stack pointer after every read.
// - the immediate and, or and xor operations combine the flags with an 8-bit immediate and write the result back.
// - flag load takes an immediate, a byte register or a memory word by indirect, displacement or absolute address.
// - flag load with post-increment reads at the pointer and then adds two to the 32-bit pointer.
// - flag store writes the flags to a byte register or as a word to memory and leaves every flag alone.
// - flag store with pre-decrement subtracts two from the pointer first and writes at the lowered address.
// - the byte-counted copy does nothing for a zero count, else moves bytes and steps both pointers until zero.
// - the word-counted copy works the same way on the 16-bit count and is skipped for a zero start count.
// - each copy form takes 8 cycles plus 4 per byte, n being the starting count.
// - these cycle counts assume code and operands in on-chip memory with no wait cycles.
module sxe_exec (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// instruction from the decoder
	input wire logic start,
	input wire sxe_pkg::sxe_cmd_t cmd,
	// on-chip memory
	output sxe_pkg::sxe_mem_t mem_o,
	input wire logic [`SXE_WORD_W-1:0] mem_rdata,
	// results back to the core
	output logic [`SXE_BYTE_W-1:0] flag_register,
	output sxe_pkg::sxe_wb_t wb_o,
	output logic sleep_req,
	output logic busy,
	output logic done
);
	import sxe_pkg::*;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic [`SXE_ADDR_W-1:0] eff_addr(input sxe_cmd_t c);
		logic [`SXE_ADDR_W-1:0] a;
		a = c.ptr[`SXE_ADDR_W-1:0];
		unique case (c.mode)
			SXE_AM_D16, SXE_AM_D24: a = c.ptr[`SXE_ADDR_W-1:0] + c.disp;
			SXE_AM_ABS16, SXE_AM_ABS24: a = c.abs_addr;
			SXE_AM_DEC: a = c.ptr[`SXE_ADDR_W-1:0] - `SXE_ADDR_STEP;
			default: a = c.ptr[`SXE_ADDR_W-1:0];
		endcase
		return a;
	endfunction

	// byte form only sees the low byte of the count
	function automatic logic count_zero(input sxe_op_t op,
		input logic [`SXE_WORD_W-1:0] cnt);
		if (op == SXE_OP_BLOCK_COPY_BYTE) begin
			return cnt[`SXE_LOW_HI:`SXE_LOW_LO] == `SXE_ZERO_BYTE;
		end
		return cnt == `SXE_ZERO_WORD;
	endfunction

	function automatic logic is_copy(input sxe_op_t op);
		return op == SXE_OP_BLOCK_COPY_BYTE || op == SXE_OP_BLOCK_COPY_WORD;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	sxe_state_t st_reg;
	sxe_state_t st_next;
	logic taken;
	logic [`SXE_BYTE_W-1:0] alu_src_flags;
	logic [`SXE_BYTE_W-1:0] alu_result;
	sxe_cmd_t alu_cmd;
	logic [`SXE_WORD_W-1:0] start_n;
	logic [`SXE_REMAIN_W-1:0] copy_total;

	assign taken = start && (st_reg.fsm == SXE_S_IDLE);
	// alu sees the new command at start, the held one afterwards
	assign alu_cmd = taken ? cmd : st_reg.cmd;
	assign alu_src_flags = st_reg.flags;
	assign start_n = (cmd.op == SXE_OP_BLOCK_COPY_BYTE) ?
		{`SXE_ZERO_BYTE, cmd.word_count_reg[`SXE_LOW_HI:`SXE_LOW_LO]} :
		cmd.word_count_reg;
	// 8 + 4n states in total
	assign copy_total = `SXE_COPY_OVH +
		({3'h0, start_n} << `SXE_COPY_PER_SH);

	sxe_flag_alu u_alu (
		.op(alu_cmd.op),
		.mode(alu_cmd.mode),
		.flag_register(alu_src_flags),
		.imm(alu_cmd.imm),
		.byte_reg(alu_cmd.byte_reg),
		.mem_word(mem_rdata),
		.result(alu_result)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.mem.rd = 1'b0;
		st_next.mem.wr = 1'b0;
		st_next.wb.sp_we = 1'b0;
		st_next.wb.pc_we = 1'b0;
		st_next.wb.ptr_we = 1'b0;
		st_next.wb.byte_we = 1'b0;
		st_next.wb.copy_we = 1'b0;
		st_next.sleep_req = 1'b0;
		st_next.done = 1'b0;
		unique case (st_reg.fsm)
			SXE_S_IDLE: begin
				if (taken) begin
					st_next.cmd = cmd;
					st_next.mem.byte_en = 1'b0;
					unique case (cmd.op)
						SXE_OP_NOP: begin
							st_next.wb.pc = cmd.pc + {20'h0, cmd.ilen};
							st_next.wb.pc_we = 1'b1;
							st_next.done = 1'b1;
						end
						SXE_OP_SLEEP: begin
							st_next.sleep_req = 1'b1;
							st_next.done = 1'b1;
						end
						SXE_OP_FLAG_AND_IMMEDIATE, SXE_OP_FLAG_OR_IMMEDIATE,
						SXE_OP_FLAG_XOR_IMMEDIATE: begin
							st_next.flags = alu_result;
							st_next.done = 1'b1;
						end
						SXE_OP_FLAG_LOAD: begin
							if (cmd.mode == SXE_AM_IMM || cmd.mode == SXE_AM_REG) begin
								st_next.flags = alu_result;
								st_next.done = 1'b1;
							end else begin
								st_next.mem.addr = eff_addr(cmd);
								st_next.mem.rd = 1'b1;
								st_next.fsm = SXE_S_RD;
							end
						end
						SXE_OP_FLAG_STORE: begin
							if (cmd.mode == SXE_AM_REG) begin
								st_next.wb.byte_out = st_reg.flags;
								st_next.wb.byte_we = 1'b1;
								st_next.done = 1'b1;
							end else begin
								// decrement happens before the write
								st_next.wb.ptr = cmd.ptr - `SXE_PTR_STEP;
								st_next.mem.addr = eff_addr(cmd);
								st_next.mem.wdata = {st_reg.flags, `SXE_PAD_BYTE};
								st_next.mem.wr = 1'b1;
								st_next.fsm = SXE_S_WR;
							end
						end
						SXE_OP_RETURN_FROM_EXCEPTION: begin
							st_next.wb.sp = cmd.sp;
							st_next.mem.addr = cmd.sp[`SXE_ADDR_W-1:0];
							st_next.mem.rd = 1'b1;
							st_next.pop = `SXE_POP_FLAGS;
							st_next.fsm = SXE_S_RD;
						end
						SXE_OP_BLOCK_COPY_BYTE, SXE_OP_BLOCK_COPY_WORD: begin
							st_next.wb.source_pointer = cmd.source_pointer;
							st_next.wb.destination_pointer = cmd.destination_pointer;
							st_next.wb.word_count_reg = cmd.word_count_reg;
							st_next.remain = copy_total - `SXE_COPY_LEAD;
							st_next.phase = `SXE_PH_READ;
							st_next.mem.byte_en = 1'b1;
							// a zero count only burns the overhead
							st_next.fsm = count_zero(cmd.op, cmd.word_count_reg) ?
								SXE_S_PAD : SXE_S_COPY;
						end
						default: st_next.done = 1'b1;
					endcase
				end
			end
			SXE_S_RD: st_next.fsm = SXE_S_DATA;
			SXE_S_DATA: begin
				if (st_reg.cmd.op == SXE_OP_RETURN_FROM_EXCEPTION) begin
					// stack pointer steps after every read
					st_next.wb.sp = st_reg.wb.sp + `SXE_SP_STEP;
					st_next.mem.addr = st_next.wb.sp[`SXE_ADDR_W-1:0];
					st_next.pop = st_reg.pop + `SXE_PH_INC;
					st_next.fsm = SXE_S_RD;
					st_next.mem.rd = 1'b1;
					unique case (st_reg.pop)
						`SXE_POP_FLAGS:
							st_next.flags = mem_rdata[`SXE_FLAG_HI:`SXE_FLAG_LO];
						`SXE_POP_PC_TOP:
							st_next.wb.pc[`SXE_PC_TOP_HI:`SXE_PC_TOP_LO] =
								mem_rdata[`SXE_LOW_HI:`SXE_LOW_LO];
						default: begin
							st_next.wb.pc[`SXE_PC_BOT_HI:`SXE_PC_BOT_LO] = mem_rdata;
							st_next.wb.pc_we = 1'b1;
							st_next.wb.sp_we = 1'b1;
							st_next.mem.rd = 1'b0;
							st_next.done = 1'b1;
							st_next.fsm = SXE_S_IDLE;
						end
					endcase
				end else begin
					st_next.flags = alu_result;
					if (st_reg.cmd.mode == SXE_AM_INC) begin
						st_next.wb.ptr = st_reg.cmd.ptr + `SXE_PTR_STEP;
						st_next.wb.ptr_we = 1'b1;
					end
					st_next.done = 1'b1;
					st_next.fsm = SXE_S_IDLE;
				end
			end
			SXE_S_WR: begin
				st_next.wb.ptr_we = (st_reg.cmd.mode == SXE_AM_DEC);
				st_next.done = 1'b1;
				st_next.fsm = SXE_S_IDLE;
			end
			SXE_S_COPY: begin
				st_next.remain = st_reg.remain - `SXE_REMAIN_STEP;
				st_next.phase = st_reg.phase + `SXE_PH_INC;
				unique case (st_reg.phase)
					`SXE_PH_READ: begin
						st_next.mem.addr = {`SXE_ZERO_BYTE, st_reg.wb.source_pointer};
						st_next.mem.rd = 1'b1;
					end
					`SXE_PH_WAIT: st_next.mem.rd = 1'b0;
					`SXE_PH_WRITE: begin
						st_next.mem.addr =
							{`SXE_ZERO_BYTE, st_reg.wb.destination_pointer};
						st_next.mem.wdata = {`SXE_ZERO_BYTE,
							mem_rdata[`SXE_LOW_HI:`SXE_LOW_LO]};
						st_next.mem.wr = 1'b1;
					end
					default: begin
						st_next.wb.source_pointer =
							st_reg.wb.source_pointer + `SXE_CNT_STEP;
						st_next.wb.destination_pointer =
							st_reg.wb.destination_pointer + `SXE_CNT_STEP;
						if (st_reg.cmd.op == SXE_OP_BLOCK_COPY_BYTE) begin
							st_next.wb.word_count_reg[`SXE_LOW_HI:`SXE_LOW_LO] =
								st_reg.wb.word_count_reg[`SXE_LOW_HI:`SXE_LOW_LO] -
								`SXE_CNT_BYTE_STEP;
						end else begin
							st_next.wb.word_count_reg =
								st_reg.wb.word_count_reg - `SXE_CNT_STEP;
						end
						if (count_zero(st_reg.cmd.op, st_next.wb.word_count_reg)) begin
							st_next.fsm = SXE_S_PAD;
						end
					end
				endcase
			end
			SXE_S_PAD: begin
				// pads out to the fixed on-chip cycle count
				st_next.remain = st_reg.remain - `SXE_REMAIN_STEP;
				if (st_reg.remain == `SXE_REMAIN_W'(0)) begin
					st_next.wb.copy_we = 1'b1;
					st_next.done = 1'b1;
					st_next.fsm = SXE_S_IDLE;
				end
			end
		endcase
		st_next.busy = (st_next.fsm != SXE_S_IDLE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.flags <= `SXE_FLAGS_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign mem_o = st_reg.mem;
	assign flag_register = st_reg.flags;
	assign wb_o = st_reg.wb;
	assign sleep_req = st_reg.sleep_req;
	assign busy = st_reg.busy;
	assign done = st_reg.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [`SXE_REMAIN_W-1:0] chk_cyc;
	logic [`SXE_REMAIN_W-1:0] chk_len;
	always_ff @(posedge clk) begin
		if (rst) begin
			chk_cyc <= '0;
			chk_len <= '0;
		end else if (taken) begin
			chk_cyc <= `SXE_REMAIN_STEP;
			chk_len <= copy_total - `SXE_REMAIN_STEP;
		end else begin
			chk_cyc <= chk_cyc + `SXE_REMAIN_STEP;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_rte_pop_order: assert property (
		st_reg.fsm == SXE_S_DATA && st_reg.pop == `SXE_POP_FLAGS &&
		st_reg.cmd.op == SXE_OP_RETURN_FROM_EXCEPTION |=>
		flag_register == $past(mem_rdata[`SXE_FLAG_HI:`SXE_FLAG_LO]) &&
		mem_o.rd && mem_o.addr == $past(mem_o.addr) + `SXE_ADDR_STEP)
		else $error("flag pop or stack step wrong");
	chk_imm_logic: assert property (
		taken && cmd.op == SXE_OP_FLAG_XOR_IMMEDIATE |=>
		done && flag_register == ($past(flag_register) ^ $past(cmd.imm)))
		else $error("xor with immediate wrong");
	chk_load_reg: assert property (
		taken && cmd.op == SXE_OP_FLAG_LOAD && cmd.mode == SXE_AM_REG |=>
		done && flag_register == $past(cmd.byte_reg))
		else $error("flag load from register wrong");
	chk_load_postinc: assert property (
		taken && cmd.op == SXE_OP_FLAG_LOAD && cmd.mode == SXE_AM_INC |->
		##1 (mem_o.rd && mem_o.addr == $past(cmd.ptr[`SXE_ADDR_W-1:0]))
		##2 (done && wb_o.ptr_we &&
		wb_o.ptr == $past(cmd.ptr, 3) + `SXE_PTR_STEP))
		else $error("post-increment load wrong");
	chk_store_keeps: assert property (
		taken && cmd.op == SXE_OP_FLAG_STORE && cmd.mode != SXE_AM_REG |=>
		mem_o.wr && mem_o.wdata[`SXE_FLAG_HI:`SXE_FLAG_LO] ==
		$past(flag_register) && $stable(flag_register) ##1
		(done && $stable(flag_register)))
		else $error("flag store wrong");
	chk_store_predec: assert property (
		taken && cmd.op == SXE_OP_FLAG_STORE && cmd.mode == SXE_AM_DEC |=>
		mem_o.wr && mem_o.addr ==
		$past(cmd.ptr[`SXE_ADDR_W-1:0]) - `SXE_ADDR_STEP)
		else $error("pre-decrement store wrong");
	chk_copy_zero: assert property (
		taken && is_copy(cmd.op) && count_zero(cmd.op, cmd.word_count_reg) |=>
		(!mem_o.rd && !mem_o.wr)[*7])
		else $error("zero count copy touched memory");
	chk_copy_end: assert property (
		st_reg.fsm == SXE_S_COPY && st_next.fsm == SXE_S_PAD |=>
		count_zero(st_reg.cmd.op, wb_o.word_count_reg))
		else $error("copy stopped before count reached zero");
	chk_copy_time: assert property (
		done && is_copy(st_reg.cmd.op) |-> chk_cyc == chk_len)
		else $error("copy cycle count wrong");
	chk_nop_pc: assert property (
		taken && cmd.op == SXE_OP_NOP |=> wb_o.pc_we && !sleep_req &&
		wb_o.pc == $past(cmd.pc) + {20'h0, $past(cmd.ilen)})
		else $error("no-operation pc wrong");

endmodule
`default_nettype wire

// ==== sxe_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxe_params.svh"

module sxe_mem_model (
	// clock
	input wire logic clk,
	// bus from the core
	input wire sxe_pkg::sxe_mem_t mem_i,
	// read data back
	output logic [`SXE_WORD_W-1:0] rdata
);
	import sxe_pkg::*;
	logic [7:0] m [0:255];
	logic [7:0] a;
	logic hold = 1'b0;
	initial begin
		rdata = 16'h0000;
		for (int i = 0; i < 256; i++) m[i] = 8'h00;
	end
	// only 256 bytes, upper address bits are ignored
	assign a = mem_i.addr[7:0];
	// ----------------------------------------
	// zero-wait answer
	// ----------------------------------------
	// data stands two cycles, then toggles so a late sample shows
	always @(posedge clk) begin
		hold <= 1'b0;
		if (mem_i.rd) begin
			if (mem_i.byte_en)
				rdata <= {~m[a], m[a]};
			else
				rdata <= {m[a], m[a + 8'h01]};
			hold <= 1'b1;
		end else if (!hold) begin
			rdata <= ~rdata;
		end
		if (mem_i.wr && mem_i.byte_en) begin
			m[a] <= mem_i.wdata[7:0];
		end else if (mem_i.wr) begin
			m[a] <= mem_i.wdata[15:8];
			m[a + 8'h01] <= mem_i.wdata[7:0];
		end
	end
endmodule
`default_nettype wire

// ==== sxe_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxe_params.svh"

module sxe_exec_bench;
	import sxe_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	sxe_cmd_t cmd = '0;
	sxe_mem_t mem_o;
	logic [15:0] mem_rdata;
	logic [7:0] flag_register;
	sxe_wb_t wb_o;
	sxe_wb_t wb_s;
	logic sleep_req;
	logic busy;
	logic done;
	logic sl_s;
	logic b_s;
	int n_errors = 0;
	int samples_checked = 0;
	int k;

	always #5 clk = ~clk;

	sxe_exec sxe_exec_inst (.clk(clk), .rst(rst), .start(start),
		.cmd(cmd), .mem_o(mem_o), .mem_rdata(mem_rdata),
		.flag_register(flag_register), .wb_o(wb_o),
		.sleep_req(sleep_req), .busy(busy), .done(done));
	sxe_mem_model sxe_mem_model_inst (.clk(clk), .mem_i(mem_o),
		.rdata(mem_rdata));

	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task end_of_test;
		$display("errors %0d, checked %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// wide enough for a strobe bit beside a 32-bit value
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// k counts cycles after the taking edge up to the done cycle
	task run;
		int i;
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		k = 1;
		b_s = busy;
		for (i = 0; i < 2000 && done !== 1'b1; i++) begin
			@(negedge clk);
			k++;
		end
		if (done !== 1'b1) begin
			n_errors++;
			end_of_test;
		end
		wb_s = wb_o;
		sl_s = sleep_req;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// the unused source carries the inverse, so a wrong pick shows
	task imm_op(input sxe_op_t op, input sxe_mode_t md,
		input logic [7:0] v, input logic [7:0] exp);
		cmd.op = op;
		cmd.mode = md;
		cmd.imm = (md == SXE_AM_REG) ? ~v : v;
		cmd.byte_reg = (md == SXE_AM_REG) ? v : ~v;
		run;
		cmp(k, 1);
		cmp(b_s, 1'b0);
		cmp(flag_register, exp);
	endtask

	task ld(input sxe_mode_t md, input logic [31:0] p,
		input logic [23:0] d, input logic [23:0] ab,
		input logic [7:0] ea, input logic [7:0] v);
		cmd.op = SXE_OP_FLAG_LOAD;
		cmd.mode = md;
		cmd.ptr = p;
		cmd.disp = d;
		cmd.abs_addr = ab;
		sxe_mem_model_inst.m[ea] = v;
		sxe_mem_model_inst.m[ea + 8'h01] = ~v;
		run;
		cmp(k, 3);
		cmp(b_s, 1'b1);
		cmp(flag_register, v);
	endtask

	task st(input sxe_mode_t md, input logic [31:0] p,
		input logic [23:0] d, input logic [7:0] ea);
		logic [7:0] f;
		f = flag_register;
		cmd.op = SXE_OP_FLAG_STORE;
		cmd.mode = md;
		cmd.ptr = p;
		cmd.disp = d;
		sxe_mem_model_inst.m[ea] = 8'hEE;
		sxe_mem_model_inst.m[ea + 8'h01] = 8'hEE;
		run;
		cmp(k, 2);
		cmp(b_s, 1'b1);
		cmp(sxe_mem_model_inst.m[ea], f);
		cmp(sxe_mem_model_inst.m[ea + 8'h01], 8'h00);
		cmp(flag_register, f);
	endtask

	task t_rte;
		sxe_mem_model_inst.m[8'h80] = 8'h2B;
		sxe_mem_model_inst.m[8'h83] = 8'h12;
		sxe_mem_model_inst.m[8'h84] = 8'h34;
		sxe_mem_model_inst.m[8'h85] = 8'h56;
		cmd.op = SXE_OP_RETURN_FROM_EXCEPTION;
		cmd.sp = 32'h00000080;
		run;
		cmp(k, 7);
		cmp(flag_register, 8'h2B);
		cmp({wb_s.pc_we, wb_s.pc}, 25'h1123456);
		cmp({wb_s.sp_we, wb_s.sp}, 33'h100000086);
	endtask

	// source A0.., destination C0..; one byte past the run stays 00
	task t_copy(input sxe_op_t op, input logic [15:0] cnt, input int n);
		int i;
		for (i = 0; i < 4; i++) begin
			sxe_mem_model_inst.m[8'hA0 + i] = 8'h5A + i;
			sxe_mem_model_inst.m[8'hC0 + i] = 8'h00;
		end
		cmd.op = op;
		cmd.word_count_reg = cnt;
		cmd.source_pointer = 16'h00A0;
		cmd.destination_pointer = 16'h00C0;
		run;
		cmp(k, 8 + 4 * n - 1);
		cmp(wb_s.copy_we, 1'b1);
		for (i = 0; i < 4; i++)
			cmp(sxe_mem_model_inst.m[8'hC0 + i], i < n ? 8'h5A + i : 8'h00);
		if (n > 0) begin
			cmp(wb_s.source_pointer, 16'h00A0 + n);
			cmp(wb_s.destination_pointer, 16'h00C0 + n);
			// byte form leaves the upper count byte alone
			cmp(wb_s.word_count_reg, (op == SXE_OP_BLOCK_COPY_BYTE) ?
				{cnt[15:8], 8'h00} : 16'h0000);
		end
	endtask

	task t_nop_sleep;
		cmd.op = SXE_OP_NOP;
		cmd.pc = 24'h001000;
		cmd.ilen = 4'h2;
		run;
		cmp(k, 1);
		cmp({wb_s.pc_we, wb_s.pc}, 25'h1001002);
		cmd.op = SXE_OP_SLEEP;
		run;
		cmp({sl_s, k[3:0]}, 5'h11);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		cmp({flag_register, busy, done}, 10'h200);
		imm_op(SXE_OP_FLAG_LOAD, SXE_AM_IMM, 8'h5A, 8'h5A);
		imm_op(SXE_OP_FLAG_AND_IMMEDIATE, SXE_AM_IMM, 8'h0F, 8'h0A);
		imm_op(SXE_OP_FLAG_OR_IMMEDIATE, SXE_AM_IMM, 8'hC0, 8'hCA);
		imm_op(SXE_OP_FLAG_XOR_IMMEDIATE, SXE_AM_IMM, 8'hFF, 8'h35);
		imm_op(SXE_OP_FLAG_LOAD, SXE_AM_REG, 8'h3C, 8'h3C);
		cmd.op = SXE_OP_FLAG_STORE;
		run;
		cmp({wb_s.byte_we, wb_s.byte_out, flag_register}, 17'h13C3C);
		ld(SXE_AM_IND, 32'h10, 24'h0, 24'h0, 8'h10, 8'h11);
		ld(SXE_AM_D16, 32'h10, 24'h10, 24'h0, 8'h20, 8'h22);
		ld(SXE_AM_D24, 32'h10, 24'h30, 24'h0, 8'h40, 8'h44);
		ld(SXE_AM_ABS16, 32'h0, 24'h0, 24'h50, 8'h50, 8'h55);
		ld(SXE_AM_ABS24, 32'h0, 24'h0, 24'h60, 8'h60, 8'h66);
		ld(SXE_AM_INC, 32'h70, 24'h0, 24'h0, 8'h70, 8'h77);
		cmp({wb_s.ptr_we, wb_s.ptr}, 33'h100000072);
		st(SXE_AM_IND, 32'h90, 24'h0, 8'h90);
		st(SXE_AM_D16, 32'h90, 24'h04, 8'h94);
		st(SXE_AM_DEC, 32'h9A, 24'h0, 8'h98);
		cmp({wb_s.ptr_we, wb_s.ptr}, 33'h100000098);
		t_rte;
		t_copy(SXE_OP_BLOCK_COPY_BYTE, 16'h0103, 3);
		t_copy(SXE_OP_BLOCK_COPY_BYTE, 16'h0100, 0);
		t_copy(SXE_OP_BLOCK_COPY_WORD, 16'h0002, 2);
		t_copy(SXE_OP_BLOCK_COPY_WORD, 16'h0000, 0);
		t_nop_sleep;
		end_of_test;
	end
endmodule
`default_nettype wire
